/* File: rtl/wmh_pkg.sv */
// Package for the wake-up mask and hibernation timer block.
// Assumes an 8-bit core register port and a 32 kHz timer clock on a pin.
package wmh_pkg;

    // Core register port width
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int MASK_N = 7;

    // Mask register byte addresses, entry order 1,2,4,5,6,7,8
    localparam logic [ADDR_W-1:0] MASK_ADDR [MASK_N] = '{
        16'h7f2c, 16'h7f2d, 16'h7f5a, 16'h7f5f, 16'h7f66, 16'h7f65, 16'h7f56};

    // Implemented bits per mask register; the rest read zero
    localparam logic [DATA_W-1:0] MASK_IMPL [MASK_N] = '{
        8'hf9, 8'h06, 8'hdc, 8'hff, 8'hff, 8'h23, 8'h0f};

    // Reset value of every mask register
    localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;

    // Countdown register and the timer source flag register
    localparam logic [ADDR_W-1:0] COUNT_ADDR   = 16'h7ff3;
    localparam logic [ADDR_W-1:0] TOSRC_ADDR   = 16'h7f2b;
    localparam logic [DATA_W-1:0] COUNT_RESET  = 8'h00;
    localparam int                TIMER_ENTRY  = 1;
    localparam int                TIMEOUT_BIT  = 2;
    localparam int                ANYKEY_BIT   = 1;

    // Tick timing: one countdown step per tick
    localparam int TICK_SECONDS        = 30;
    localparam int SLOW_CLK_HZ         = 32768;
    localparam int SLOW_EDGES_PER_TICK = TICK_SECONDS * SLOW_CLK_HZ;
    localparam int PRESCALE_W          = 20;

    // Per-register byte groups
    typedef logic [MASK_N-1:0][DATA_W-1:0] wmh_bytes_t;

    // Core register request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              wrEn;
        logic              rdEn;
        logic [DATA_W-1:0] wrData;
    } wmh_bus_req_t;

    // Results toward the core
    typedef struct packed {
        logic [DATA_W-1:0] rdData;
        logic              irq;
        logic              wake;
    } wmh_out_t;

endpackage : wmh_pkg

/* File: rtl/wmh_tick_gen.sv */
// Tick generator: synchronises the 32 kHz clock pin and divides it.
// Assumes the slow clock is far below clk; restart realigns the divider.
`timescale 1ns/10ps
module wmh_tick_gen import wmh_pkg::*; #(
    parameter int EDGES = SLOW_EDGES_PER_TICK
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Slow clock pin and control
    input  wire logic slowClkPin,
    input  wire logic restart,
    // One-cycle tick
    output logic      tick
);

    localparam logic [PRESCALE_W-1:0] LAST = PRESCALE_W'(EDGES - 1);

    // Whole state of the divider
    typedef struct packed {
        logic [2:0]            sync;    // Synchroniser chain
        logic                  stable;  // Agreed slow clock level
        logic [PRESCALE_W-1:0] cnt;     // Slow edges this tick
        logic                  tick;    // Registered tick
    } wmh_tick_state_t;

    wmh_tick_state_t st;
    wmh_tick_state_t next_st;

    // Divide agreed rising edges down to one tick
    always_comb begin
        logic rise;
        rise    = 1'b0;
        next_st = st;
        next_st.sync = {st.sync[1:0], slowClkPin};
        next_st.tick = 1'b0;
        // Change counts once stages two and three agree
        if (st.sync[1] == st.sync[2]) begin
            next_st.stable = st.sync[2];
            rise = st.sync[2] && !st.stable;
        end
        if (restart) begin
            next_st.cnt = '0;
        end else if (rise) begin
            if (st.cnt == LAST) begin
                next_st.cnt  = '0;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule : wmh_tick_gen

/* File: rtl/wmh_wake_mask.sv */
// Wake-up mask registers and hibernation countdown timer.
// Assumes neighbouring logic holds the wake source flags and feeds them in.
//
// Behaviour
// - Mask bit one blocks its source interrupt
// - Mask bit zero lets source interrupt through
// - Masked flag stays readable, raises no interrupt
// - All mask registers reset to zero
// - Mask bits read/write; reserved read zero
// - First mask: power, bus, alarm sources
// - Second mask: timer timeout, any-key wake
// - Fourth mask: edge sources 07..02 subset
// - Fifth mask: edge sources 10 to 17
// - Sixth mask: edge sources 20 to 27
// - Seventh mask: transfer done, fan inputs
// - Eighth mask: four pin wake sources
// - Timer is 8-bit binary down counter
// - Each count step lasts 30 seconds
// - At zero timer stops and holds zero
// - Expiry raises wake event to core
// - Timer runs from the 32 kHz clock
// - Non-zero write loads and starts countdown
// - Source flag sticky until written one
// - Timeout flag sets when countdown hits zero
`timescale 1ns/10ps
module wmh_wake_mask import wmh_pkg::*; #(
    parameter int TICK_EDGES = SLOW_EDGES_PER_TICK
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Core register port
    input  wire wmh_bus_req_t req,
    // Wake source flags from the source registers
    input  wire wmh_bytes_t   srcFlags,
    // Slow timer clock pin
    input  wire logic         slowClkPin,
    // Results toward the core
    output wmh_out_t          core,
    output logic              timeoutFlag
);

    // Whole state of the block
    typedef struct packed {
        wmh_bytes_t        mask;    // Mask registers
        logic [DATA_W-1:0] count;   // Countdown value
        logic              toFlag;  // Sticky timeout flag
        logic              irq;     // Registered interrupt
        logic              wake;    // Expiry pulse
        logic [DATA_W-1:0] rdData;  // Read result
    } wmh_state_t;

    wmh_state_t st;
    wmh_state_t next_st;

    logic              tick;        // One 30 s step
    logic              countWr;     // Core writes countdown
    logic [MASK_N-1:0] maskHit;     // Address hits mask entry
    logic [MASK_N-1:0] pending;     // Unmasked flag per entry
    wmh_bytes_t        effFlags;    // Flags with local timeout
    logic [MASK_N-1:0] resvHit;     // Reserved mask bit held

    assign countWr = req.wrEn && (req.addr == COUNT_ADDR);

    // Divider on the slow clock; restarted by each load
    wmh_tick_gen #(
        .EDGES      (TICK_EDGES)
    ) u_tick (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .slowClkPin (slowClkPin),
        .restart    (countWr),
        .tick       (tick)
    );

    // Per-entry decode and gating
    for (genvar i = 0; i < MASK_N; i++) begin : g_entry
        assign maskHit[i] = (req.addr == MASK_ADDR[i]);
        if (i == TIMER_ENTRY) begin : g_timer
            // Timeout bit comes from the local flag
            assign effFlags[i] = {srcFlags[i][DATA_W-1:TIMEOUT_BIT+1], st.toFlag,
                                  srcFlags[i][TIMEOUT_BIT-1:0]};
        end else begin : g_plain
            assign effFlags[i] = srcFlags[i];
        end
        // Mask one blocks, mask zero passes
        assign pending[i] = |(effFlags[i] & ~st.mask[i] & MASK_IMPL[i]);
        assign resvHit[i] = |(st.mask[i] & ~MASK_IMPL[i]);
    end

    // Next-state logic
    always_comb begin
        logic [DATA_W-1:0] rd;
        rd      = '0;
        next_st = st;
        next_st.wake = 1'b0;

        // Mask writes keep implemented bits only
        for (int i = 0; i < MASK_N; i++) begin
            if (req.wrEn && maskHit[i]) begin
                next_st.mask[i] = req.wrData & MASK_IMPL[i];
            end
            if (maskHit[i]) begin
                rd = st.mask[i];
            end
        end

        // Countdown: write wins over a tick in the same cycle
        if (countWr) begin
            next_st.count = req.wrData;
        end else if (tick && st.count != '0) begin
            next_st.count = st.count - 1'b1;
            if (st.count == 8'h01) begin
                next_st.wake = 1'b1;
            end
        end

        // Timeout flag: write-one clears, expiry set wins
        if (req.wrEn && req.addr == TOSRC_ADDR && req.wrData[TIMEOUT_BIT]) begin
            next_st.toFlag = 1'b0;
        end
        if (next_st.wake) begin
            next_st.toFlag = 1'b1;
        end

        // Read answers, unmapped reads give zero
        if (req.addr == COUNT_ADDR) begin
            rd = st.count;
        end else if (req.addr == TOSRC_ADDR) begin
            rd = '0;
            rd[TIMEOUT_BIT] = st.toFlag;
            rd[ANYKEY_BIT]  = srcFlags[TIMER_ENTRY][ANYKEY_BIT];
        end
        if (req.rdEn) begin
            next_st.rdData = rd;
        end

        // Interrupt from every unmasked flag
        next_st.irq = |pending;
    end

    // State register; masks come up all clear, every source passes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign core.rdData = st.rdData;
    assign core.irq    = st.irq;
    assign core.wake   = st.wake;
    assign timeoutFlag = st.toFlag;

    // Helper: a write to the fifth mask, later read back
    logic maskWr3;
    assign maskWr3 = req.wrEn && maskHit[3];

    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // All flags masked means no interrupt next cycle
    property p_maskBlocks;
        (srcFlags[0] != '0) && (st.mask[0] == MASK_IMPL[0]) && (st.mask == next_st.mask)
            && (effFlags[1] == '0) && (srcFlags[6:2] == '0)
            |=> !core.irq;
    endproperty
    a_maskBlocks: assert property (p_maskBlocks)
        else $error("masked source raised interrupt");

    // Unmasked flag raises the interrupt next cycle
    property p_unmaskPasses;
        srcFlags[3][0] && !st.mask[3][0] |=> core.irq;
    endproperty
    a_unmaskPasses: assert property (p_unmaskPasses)
        else $error("unmasked source gave no interrupt");

    // Mask write then read returns implemented bits
    sequence s_maskWrite;
        maskWr3 && !req.rdEn;
    endsequence
    sequence s_maskRead;
        req.rdEn && maskHit[3] && !req.wrEn;
    endsequence
    property p_maskReadBack;
        logic [DATA_W-1:0] v;
        (s_maskWrite, v = req.wrData) ##1 !maskWr3 ##1 s_maskRead |=> core.rdData == v;
    endproperty
    a_maskReadBack: assert property (p_maskReadBack)
        else $error("mask read back wrong");

    // Reserved bits of the second mask never read one
    property p_reservedZero;
        req.rdEn && maskHit[1] |=> (core.rdData & ~MASK_IMPL[1]) == '0;
    endproperty
    a_reservedZero: assert property (p_reservedZero)
        else $error("reserved mask bit read as one");

    // A tick with non-zero count steps down by one
    property p_decrement;
        tick && !countWr && st.count != '0 |=> st.count == $past(st.count) - 8'h01;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("countdown did not step by one");

    // Zero holds across ticks until a write
    property p_holdZero;
        st.count == '0 && !countWr |=> st.count == '0;
    endproperty
    a_holdZero: assert property (p_holdZero)
        else $error("countdown left zero without a write");

    // Last step gives one wake pulse and the flag
    sequence s_lastStep;
        tick && !countWr && st.count == 8'h01;
    endsequence
    property p_expiry;
        s_lastStep |=> core.wake && timeoutFlag ##1 !core.wake;
    endproperty
    a_expiry: assert property (p_expiry)
        else $error("expiry gave no single wake pulse");

    // Write loads the countdown value
    property p_load;
        countWr |=> st.count == $past(req.wrData);
    endproperty
    a_load: assert property (p_load)
        else $error("countdown load lost");

    // Flag stays set unless cleared by a write of one
    property p_sticky;
        timeoutFlag && !(req.wrEn && req.addr == TOSRC_ADDR && req.wrData[TIMEOUT_BIT])
            |=> timeoutFlag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("timeout flag dropped by itself");

    // Wake pulse only after a counting step
    property p_wakeCause;
        core.wake |-> $past(tick) && $past(st.count) == 8'h01;
    endproperty
    a_wakeCause: assert property (p_wakeCause)
        else $error("wake pulse without expiry");

    // Registers come out of reset cleared
    property p_resetState;
        $past(sys_rst) |-> (st.mask == '0) && (st.count == '0) && !timeoutFlag && !core.irq;
    endproperty
    a_resetState: assert property (p_resetState)
        else $error("state not cleared after reset");

    // First mask keeps power, bus and alarm bits only
    property p_landMask0;
        req.wrEn && maskHit[0] |=> st.mask[0] == ($past(req.wrData) & MASK_IMPL[0]);
    endproperty
    a_landMask0: assert property (p_landMask0)
        else $error("first mask write landed wrong");

    // Second mask keeps timeout and any-key bits only
    property p_landMask1;
        req.wrEn && maskHit[1] |=> st.mask[1] == ($past(req.wrData) & MASK_IMPL[1]);
    endproperty
    a_landMask1: assert property (p_landMask1)
        else $error("second mask write landed wrong");

    // Fourth mask keeps its five edge bits only
    property p_landMask2;
        req.wrEn && maskHit[2] |=> st.mask[2] == ($past(req.wrData) & MASK_IMPL[2]);
    endproperty
    a_landMask2: assert property (p_landMask2)
        else $error("fourth mask write landed wrong");

    // Sixth mask takes all eight edge bits
    property p_landMask4;
        req.wrEn && maskHit[4] |=> st.mask[4] == ($past(req.wrData) & MASK_IMPL[4]);
    endproperty
    a_landMask4: assert property (p_landMask4)
        else $error("sixth mask write landed wrong");

    // Seventh mask keeps transfer and fan bits only
    property p_landMask5;
        req.wrEn && maskHit[5] |=> st.mask[5] == ($past(req.wrData) & MASK_IMPL[5]);
    endproperty
    a_landMask5: assert property (p_landMask5)
        else $error("seventh mask write landed wrong");

    // Eighth mask keeps the four pin bits only
    property p_landMask6;
        req.wrEn && maskHit[6] |=> st.mask[6] == ($past(req.wrData) & MASK_IMPL[6]);
    endproperty
    a_landMask6: assert property (p_landMask6)
        else $error("eighth mask write landed wrong");

    // Writes to other addresses leave the masks alone
    property p_unmappedWrite;
        req.wrEn && (maskHit == '0) |=> st.mask == $past(st.mask);
    endproperty
    a_unmappedWrite: assert property (p_unmappedWrite)
        else $error("mask changed by a foreign write");

    // Reserved mask bits never hold a one
    property p_noReservedMask;
        resvHit == '0;
    endproperty
    a_noReservedMask: assert property (p_noReservedMask)
        else $error("reserved mask bit set");

    // Read result stands until the next read
    property p_readStands;
        !req.rdEn |=> $stable(core.rdData);
    endproperty
    a_readStands: assert property (p_readStands)
        else $error("read result changed without a read");

    // Set timeout flag under its mask raises no interrupt
    property p_timeoutMasked;
        timeoutFlag && st.mask[TIMER_ENTRY][TIMEOUT_BIT] && (srcFlags == '0) |=> !core.irq;
    endproperty
    a_timeoutMasked: assert property (p_timeoutMasked)
        else $error("masked timeout raised interrupt");

    // Zero write stops the countdown with no wake
    property p_zeroWrite;
        countWr && (req.wrData == '0) |=> (st.count == '0) && !core.wake;
    endproperty
    a_zeroWrite: assert property (p_zeroWrite)
        else $error("zero write did not stop quietly");

    // Count moves only on a tick or a write
    property p_noTickHold;
        !tick && !countWr |=> st.count == $past(st.count);
    endproperty
    a_noTickHold: assert property (p_noTickHold)
        else $error("countdown moved without a tick");

    // Write of one clears the timeout flag
    property p_flagClear;
        req.wrEn && (req.addr == TOSRC_ADDR) && req.wrData[TIMEOUT_BIT]
            && !(tick && st.count == 8'h01) |=> !timeoutFlag;
    endproperty
    a_flagClear: assert property (p_flagClear)
        else $error("timeout flag not cleared by write");

endmodule : wmh_wake_mask

/* File: sim/wmh_slow_clk_model.sv */
// Model of the slow timer clock source that drives the timer pin.
// Assumes a free-running clock; the half period is shortened for simulation.
`timescale 1ns/10ps
module wmh_slow_clk_model #(
    parameter int HALF_NS = 100 // Half period in ns
) (
    // Slow clock toward the timer pin
    output logic slowClk
);
    // Free-running slow clock, offset in phase from clk
    initial begin
        slowClk = 1'b0;
        #7;
        forever #(HALF_NS) slowClk = ~slowClk;
    end
endmodule : wmh_slow_clk_model

/* File: sim/wmh_wake_mask_test.sv */
// Self-checking bench for the wake mask registers and the countdown timer.
// Assumes the slow clock model feeds the timer pin; one tick is 4 slow edges.
`timescale 1ns/10ps
module wmh_wake_mask_test import wmh_pkg::*;;
    logic         clk;         // Core clock
    logic         sys_rst;     // Async reset
    logic         slowClk;     // Slow timer clock
    logic         rdPend;      // Read taken last edge
    logic         timeoutFlag; // Sticky timeout flag
    wmh_bus_req_t req;         // Register request
    wmh_bytes_t   srcFlags;    // Source flag bytes
    wmh_out_t     core;        // Results toward core
    logic [7:0]   expQ[$];     // Expected read data
    logic [7:0]   f;           // Flag pattern
    logic [7:0]   m;           // Mask pattern
    logic [31:0]  seed = 32'h0000a479; // Xorshift state
    int           num_errors;  // Mismatch count
    int           checked;     // Comparison count
    int           cycles;      // Clock cycle count
    int           wakes;       // Wake pulses seen
    int           start;       // Timer start cycle
    int           n;           // Wait counter

    // Design under test with a short tick
    wmh_wake_mask #(.TICK_EDGES(4)) dut_u (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .req         (req),
        .srcFlags    (srcFlags),
        .slowClkPin  (slowClk),
        .core        (core),
        .timeoutFlag (timeoutFlag)
    );

    // Slow clock source, 200 ns period
    wmh_slow_clk_model #(.HALF_NS(100)) slow_u (
        .slowClk (slowClk)
    );

    // Core clock, 5 ns period
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Xorshift random byte
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    // Compare seen against expected
    task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Counts and verdict
    task final_report();
        $display("Checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // One write strobe
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        req.addr   = a;
        req.wrData = d;
        req.wrEn   = 1'b1;
        @(negedge clk);
        req.wrEn   = 1'b0;
    endtask : wr

    // One read strobe, expected value noted
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        req.addr = a;
        req.rdEn = 1'b1;
        expQ.push_back(e);
        @(negedge clk);
        req.rdEn = 0;
    endtask : rd

    // Read answer arrives one edge after the strobe
    always @(posedge clk) rdPend <= req.rdEn;
    always @(negedge clk) begin
        if (rdPend === 1'b1) begin
            if (expQ.size() == 0) begin
                check(core.rdData, 8'hxx, "unexpected read");
            end else begin
                check(core.rdData, expQ.pop_front(), "rdData");
            end
        end
        if (core.wake === 1'b1) wakes++;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        req = '0;
        srcFlags = '0;
        sys_rst = 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        // Reset values and an unmapped read
        for (int i = 0; i < MASK_N; i++) rd(MASK_ADDR[i], MASK_RESET);
        rd(COUNT_ADDR, COUNT_RESET);
        rd(16'h7f00, 8'h00);
        $display("Test reset values done");
        // Mask access; reserved bits stay zero
        for (int i = 0; i < MASK_N; i++) begin
            m = rnd();
            wr(MASK_ADDR[i], m);
            rd(MASK_ADDR[i], m & MASK_IMPL[i]);
            wr(MASK_ADDR[i], 8'hff);
            rd(MASK_ADDR[i], MASK_IMPL[i]);
        end
        wr(16'h7f00, 8'h00);
        rd(MASK_ADDR[0], MASK_IMPL[0]);
        $display("Test register access done");
        // Masked and unmasked sources
        for (int i = 0; i < MASK_N; i++) begin
            for (int k = 0; k < 6; k++) begin
                f = (k == 1) ? MASK_IMPL[i] : rnd() & MASK_IMPL[i];
                if (i == TIMER_ENTRY) f[TIMEOUT_BIT] = 1'b0;
                m = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : rnd();
                wr(MASK_ADDR[i], m);
                @(negedge clk) srcFlags[i] = f;
                repeat (2) @(negedge clk);
                check({7'h0, core.irq}, {7'h0, |(f & ~m)}, "irq");
                srcFlags[i] = 8'h00;
                repeat (2) @(negedge clk);
            end
        end
        $display("Test masking done");
        // Countdown from two, expiry, wake and hold at zero
        wr(MASK_ADDR[TIMER_ENTRY], 8'h00);
        start = cycles;
        wr(COUNT_ADDR, 8'h02);
        rd(COUNT_ADDR, 8'h02);
        for (n = 0; n < 1000 && core.wake !== 1'b1; n++) @(negedge clk);
        check({7'h0, (cycles - start) inside {[275:340]}}, 8'h01, "tick time");
        check({7'h0, timeoutFlag}, 8'h01, "timeout flag");
        @(negedge clk);
        check({7'h0, core.irq}, 8'h01, "timeout irq");
        rd(TOSRC_ADDR, 8'h04);
        wr(MASK_ADDR[TIMER_ENTRY], 8'h04);
        repeat (2) @(negedge clk);
        check({7'h0, core.irq}, 8'h00, "masked timeout irq");
        rd(TOSRC_ADDR, 8'h04);
        repeat (400) @(negedge clk);
        rd(COUNT_ADDR, 8'h00);
        check(8'(wakes), 8'h01, "wake pulses");
        wr(TOSRC_ADDR, 8'h04);
        rd(TOSRC_ADDR, 8'h00);
        // Zero write stops a running count
        wr(COUNT_ADDR, 8'h03);
        wr(COUNT_ADDR, 8'h00);
        repeat (400) @(negedge clk);
        check(8'(wakes), 8'h01, "stopped timer");
        $display("Test timer done");
        final_report();
    end
endmodule : wmh_wake_mask_test
